// ===== common/mcd_pkg.sv
// microword control decode: field layout, register map, reset values
// assumes a 48-bit microword captured from control store every cycle while ctrl bit 0 (freeze) is clear
package mcd_pkg;
	// ------------------------------------------------------------
	// microword fields (bit positions)
	// ------------------------------------------------------------
	localparam int MW_W       = 48;
	localparam int F_FO_LO    = 46;
	localparam int F_FI_LO    = 44;
	localparam int F_FGP_LO   = 40;
	localparam int F_IMB_LO   = 37;
	localparam int F_RGP_LO   = 32;
	localparam int F_DOE      = 31;
	localparam int F_IRW      = 30;
	localparam int F_ADL      = 29;
	localparam int F_FRW      = 28;
	localparam int F_ED1      = 27;
	localparam int F_KS_LO    = 24;
	localparam int F_IER      = 23;
	localparam int F_STATUS_WORD_ADDR_LO  = 20;
	localparam int F_NC2      = 19;
	localparam int F_NC1      = 18;
	localparam int F_CCR      = 17;
	localparam int F_EXT      = 16;
	localparam int F_RRE      = 15;
	localparam int F_LD2      = 14;
	localparam int F_SJM      = 13;
	localparam int F_IST      = 12;
	localparam int F_DBY      = 11;
	// ------------------------------------------------------------
	// register map (byte addresses) and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STAT   = 8'h04;
	localparam logic [7:0] A_EMAR   = 8'h08;
	localparam logic [7:0] A_MASK   = 8'h0C;
	localparam logic [7:0] A_GRP    = 8'h10;
	localparam logic [47:0] PIPE_RST = 48'h0;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [15:0] MAR_RST  = 16'h0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_DEC = 2'h3;
	localparam int          SYNC_W   = 11;
	// ------------------------------------------------------------
	// k-bus source select
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		kbus_zeros        = 3'h0,
		kbus_alu_out      = 3'h1,
		kbus_mem_data     = 3'h2,
		kbus_instr        = 3'h3,
		kbus_ones         = 3'h4,
		kbus_alu_out_inv  = 3'h5,
		kbus_mem_data_inv = 3'h6,
		kbus_instr_inv    = 3'h7
	} mcd_kbus_type;
endpackage

// ===== design/mcd_decode.sv
// microword control decode with axi4-lite access to its tables
// assumes sequencer, arrays and control store on aclk; pins async
`timescale 1ns/10ps
module mcd_decode (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [47:0] cstore_word,
	input  wire logic [8:0]  seq_ma,
	input  wire logic        flag_output,
	output logic [8:0]       micro_addr,
	output logic             seq_input_bit3,
	output logic             seq_int_req,
	output logic [8:0]       decode_addr,
	input  wire logic        ready_pin,
	input  wire logic        hold_pin,
	input  wire logic        int_req_pin,
	output logic             hold_ack,
	output logic             int_enable_out,
	output logic [6:0]       status_strobes,
	input  wire logic        flag_zero,
	input  wire logic        flag_parity,
	input  wire logic        flag_sign,
	input  wire logic        flag_carry,
	input  wire logic        flag_half_carry,
	input  wire logic [7:0]  array1_data,
	input  wire logic [7:0]  array2_data,
	input  wire logic [15:0] imar_in,
	output logic [15:0]      ext_addr,
	input  wire logic [7:0]  dbus_in,
	output logic [7:0]       dbus_out,
	output logic             dbus_oe,
	output logic [7:0]       kbus,
	output logic [7:0]       mask_bus,
	output logic [3:0]       reg_grp1,
	output logic [3:0]       reg_grp2,
	output logic             array1_clk_en,
	output logic             array2_clk_en,
	output logic             carry_split,
	output logic [7:0]       instr_reg
);
	import mcd_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [47:0]       pipe_r;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [7:0]        ir_r;
	logic [15:0]       emar_r;
	logic [2:0]        psw_r;
	logic              int_enable_out_r;
	logic              freeze_r;
	logic [7:0]        mask_tab [32];
	logic [7:0]        grp_tab [32];
	logic              aw_hold_r;
	logic [7:0]        aw_addr_r;
	logic              w_hold_r;
	logic [31:0]       w_data_r;
	logic              w_strb0_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;

	// ------------------------------------------------------------
	// microword fields
	// ------------------------------------------------------------
	wire       ext    = pipe_r[F_EXT];
	wire       interrupt_strobe    = pipe_r[F_IST];
	wire       ld2    = pipe_r[F_LD2];
	wire       secondary_jump    = pipe_r[F_SJM];
	wire       reg_lookup_enable    = pipe_r[F_RRE];
	wire       cond_clock_ready    = pipe_r[F_CCR];
	wire       nc1    = pipe_r[F_NC1];
	wire       nc2    = pipe_r[F_NC2];
	wire       double_byte_sel    = pipe_r[F_DBY];
	wire       int_enable_write    = pipe_r[F_IER];
	wire       ed1    = pipe_r[F_ED1];
	wire       flag_reg_write    = pipe_r[F_FRW];
	wire       addr_load    = pipe_r[F_ADL];
	wire       instr_reg_write    = pipe_r[F_IRW];
	wire       data_out_enable    = pipe_r[F_DOE];
	wire [2:0] status_word_addr   = pipe_r[F_STATUS_WORD_ADDR_LO +: 3];
	wire [2:0] ks     = pipe_r[F_KS_LO +: 3];
	wire [4:0] reg_group_field    = pipe_r[F_RGP_LO +: 5];
	wire [2:0] mask_select_field    = pipe_r[F_IMB_LO +: 3];
	wire       rdy_s  = sync2_r[10];
	wire       hold_s = sync2_r[9];
	wire       intr_s = sync2_r[8];
	wire [7:0] mdat_s = sync2_r[7:0];

	// ------------------------------------------------------------
	// lookups
	// ------------------------------------------------------------
	// macro condition test: ir[5:4] picks flag, ir[3] its sense
	function automatic logic jump_cond(
		input logic [2:0] cc,
		input logic [3:0] f,
		input logic       sec
	);
		jump_cond = sec & (f[cc[2:1]] == cc[0]);
	endfunction

	// status strobe code per status field value; one strobe each for values 1 to 7, none for 0 or while ext sees ready
	function automatic logic [6:0] strobe_dec(input logic [3:0] a);
		if (a[3]) begin
			strobe_dec = 7'h00;
		end else if (a[2:0] == 3'h0) begin
			strobe_dec = 7'h00;
		end else begin
			strobe_dec = 7'(7'h01 << (a[2:0] - 3'h1));
		end
	endfunction

	wire [3:0] jflags = {psw_r[2], psw_r[1], flag_carry, psw_r[0]};
	wire       jres   = jump_cond(ir_r[5:3], jflags, secondary_jump);
	wire       ma0    = ext ? rdy_s : (interrupt_strobe ? hold_s : seq_ma[0]);
	wire       stall  = cond_clock_ready & ext & ~rdy_s;
	wire       st_off = ext & rdy_s;
	wire [7:0] op_grp = reg_lookup_enable ? {2'h0, ir_r[5:4], 2'h0, ir_r[1:0]} : 8'h00;
	wire [7:0] grp    = grp_tab[reg_group_field] | op_grp;
	wire [4:0] midx   = {mask_select_field, flag_carry, flag_half_carry};
	wire [7:0] shared = ed1 ? array2_data : array1_data;
	logic [7:0] kmux;

	always_comb begin
		case (mcd_kbus_type'(ks))
			kbus_zeros:        kmux = 8'h00;
			kbus_alu_out:      kmux = shared;
			kbus_mem_data:     kmux = mdat_s;
			kbus_instr:        kmux = ir_r;
			kbus_ones:         kmux = 8'hFF;
			kbus_alu_out_inv:  kmux = ~shared;
			kbus_mem_data_inv: kmux = ~mdat_s;
			kbus_instr_inv:    kmux = ~ir_r;
			default:           kmux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// bit 0 wait loops on ready or hold
	assign micro_addr[0]   = ma0;
	assign micro_addr[3:1] = seq_ma[3:1];
	assign micro_addr[4]   = seq_ma[4] & ~(interrupt_strobe & hold_s);
	assign micro_addr[8:5] = seq_ma[8:5];
	// sequencer inputs are active low: a high here pulls bit 3 low
	assign seq_input_bit3  = jres | ld2;
	assign decode_addr     = {secondary_jump, ir_r};
	assign seq_int_req     = interrupt_strobe & (intr_s | hold_s);
	assign hold_ack        = hold_s & ~ext;
	assign status_strobes  = strobe_dec({st_off, status_word_addr});
	assign array1_clk_en   = ~nc1 & ~stall;
	assign array2_clk_en   = ~nc2 & ~stall;
	assign carry_split     = double_byte_sel;
	assign kbus            = kmux;
	assign mask_bus        = mask_tab[midx];
	assign reg_grp1        = grp[3:0];
	assign reg_grp2        = grp[7:4];
	assign dbus_out        = shared;
	assign dbus_oe         = data_out_enable;
	assign ext_addr        = emar_r;
	assign instr_reg       = ir_r;
	assign int_enable_out  = int_enable_out_r;

	// ------------------------------------------------------------
	// pipeline and datapath registers
	// ------------------------------------------------------------
	// freeze is a debug hold of the current word until ctrl bit 0 is cleared, then capture resumes every cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pipe_r <= PIPE_RST;
		end else if (!freeze_r) begin
			pipe_r <= cstore_word;
		end
	end

	// first stage feeds only the second
	always_ff @(posedge aclk) begin
		sync1_r <= {ready_pin, hold_pin, int_req_pin, dbus_in};
		sync2_r <= sync1_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_r   <= BYTE_RST;
			emar_r <= MAR_RST;
			psw_r  <= 3'h0;
			int_enable_out_r <= 1'b0;
		end else begin
			if (instr_reg_write) begin
				ir_r <= mdat_s;
			end
			if (addr_load) begin
				emar_r <= imar_in;
			end
			if (flag_reg_write) begin
				psw_r <= {flag_sign, flag_parity, flag_zero};
			end
			if (int_enable_write) begin
				int_enable_out_r <= flag_output;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	wire aw_hs  = s_axi_awvalid & s_axi_awready;
	wire w_hs   = s_axi_wvalid & s_axi_wready;
	wire ar_hs  = s_axi_arvalid & s_axi_arready;
	wire do_wr  = aw_hold_r & w_hold_r & ~bvalid_r;
	wire [7:0] wa = aw_addr_r;
	wire wr_ok  = (wa == A_CTRL) | (wa == A_MASK) | (wa == A_GRP);
	wire [4:0] widx = w_data_r[12:8];
	wire [7:0] wval = w_data_r[7:0];
	logic [31:0] rd_mux;
	logic        rd_ok;

	assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (s_axi_araddr)
			A_CTRL:  rd_mux = {31'h0, freeze_r};
			A_STAT:  rd_mux = {20'h0, int_enable_out_r, psw_r, ir_r};
			A_EMAR:  rd_mux = {16'h0, emar_r};
			default: rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= BYTE_RST;
			w_data_r  <= 32'h0;
			w_strb0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OK;
		end else begin
			if (aw_hs) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_hold_r  <= 1'b1;
				w_data_r  <= s_axi_wdata;
				w_strb0_r <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_ok ? RESP_OK : RESP_DEC;
			end else if (bvalid_r & s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// tables reset to zero; only byte lane 0 carries table data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freeze_r <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				mask_tab[i] <= BYTE_RST;
				grp_tab[i]  <= BYTE_RST;
			end
		end else if (do_wr & w_strb0_r) begin
			if (wa == A_CTRL) begin
				freeze_r <= w_data_r[0];
			end
			if (wa == A_MASK) begin
				mask_tab[widx] <= wval;
			end
			if (wa == A_GRP) begin
				grp_tab[widx] <= wval;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= RESP_OK;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_ok ? RESP_OK : RESP_DEC;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_MA4_GATE: assert property (
		interrupt_strobe && hold_s |-> !micro_addr[4])
		else $error("bit 4 not forced low");
	AST_MA0_READY: assert property (
		ext |-> micro_addr[0] == rdy_s)
		else $error("bit 0 not following ready");
	AST_SX3: assert property (
		ld2 |-> seq_input_bit3)
		else $error("load_two lost");
	AST_FREEZE: assert property (
		cond_clock_ready && ext && !rdy_s |-> !array1_clk_en && !array2_clk_en)
		else $error("arrays clocked while waiting");
	AST_NC: assert property (
		!stall |-> array1_clk_en == !nc1 && array2_clk_en == !nc2)
		else $error("array clock gate wrong");
	AST_STAT_OFF: assert property (
		ext && rdy_s |-> status_strobes == 7'h00)
		else $error("status strobes not disabled");
	AST_IR_LOAD: assert property (
		instr_reg_write |=> instr_reg == $past(mdat_s))
		else $error("instruction register not loaded");
	AST_IR_KEEP: assert property (
		!instr_reg_write |=> $stable(instr_reg))
		else $error("instruction register changed");
	AST_INT_ENABLE_OUT: assert property (
		int_enable_write |=> int_enable_out == $past(flag_output))
		else $error("interrupt enable not written");
	AST_MAR: assert property (
		addr_load |=> ext_addr == $past(imar_in))
		else $error("external address not loaded");
	AST_HOLD_ACK: assert property (
		ext |-> !hold_ack)
		else $error("hold_ack during external test");
	AST_INTREQ: assert property (
		!interrupt_strobe |-> !seq_int_req)
		else $error("interrupt without strobe");
	AST_PIPE: assert property (
		!freeze_r |=> pipe_r == $past(cstore_word))
		else $error("pipeline not captured");
	AST_BRESP: assert property (
		do_wr |=> s_axi_bvalid)
		else $error("write response missing");

	COV_WAIT: cover property (ext && !rdy_s ##1 ext && rdy_s);
	COV_HOLD: cover property (interrupt_strobe && hold_s);
	COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== tb/mcd_bus_model.sv
// partner model: memory or i/o device answering status strobes
// assumes the decode block's strobes and data enable, all on aclk
`timescale 1ns/10ps
module mcd_bus_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [6:0] status_strobes,
	input  wire logic       dbus_oe,
	input  wire logic       hold_req,
	input  wire logic       int_req,
	input  wire logic [3:0] wait_cycles,
	input  wire logic [7:0] rd_data,
	output logic            ready_pin,
	output logic            hold_pin,
	output logic            int_req_pin,
	output logic [7:0]      dbus_in
);
	logic [3:0] cnt_r;
	logic [7:0] last_r;
	assign hold_pin    = hold_req;
	assign int_req_pin = int_req;
	// released bus shows the inverse of the last byte, not a kept value
	assign dbus_in = (ready_pin && !dbus_oe) ? rd_data : ~last_r;
	// reset gives the released bus a known level before the first answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r     <= 4'h0;
			ready_pin <= 1'b0;
			last_r    <= 8'h00;
		end else begin
			// slow answer after the programmed delay
			cnt_r     <= (|status_strobes) ? cnt_r + 4'h1 : 4'h0;
			ready_pin <= (|status_strobes) && (cnt_r >= wait_cycles);
			if (ready_pin)
				last_r <= rd_data;
		end
	end
endmodule

// ===== tb/tb_top.sv
// testbench for the microword control decode block
// assumes mcd_pkg, mcd_decode and mcd_bus_model are compiled first
`timescale 1ns/10ps
module tb_top;
	import mcd_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb, reg_grp1, reg_grp2, wait_cycles;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [47:0] cstore_word;
	logic [8:0]  seq_ma, micro_addr, decode_addr;
	logic        flag_output, seq_input_bit3, seq_int_req, hold_ack;
	logic        ready_pin, hold_pin, int_req_pin, int_enable_out;
	logic        flag_zero, flag_parity, flag_sign, flag_carry;
	logic        flag_half_carry, dbus_oe, array1_clk_en, array2_clk_en;
	logic        carry_split, hold_req, int_req;
	logic [6:0]  status_strobes;
	logic [7:0]  array1_data, array2_data, dbus_in, dbus_out, kbus;
	logic [7:0]  mask_bus, instr_reg, rd_data;
	logic [7:0]  kx [8];
	logic [15:0] imar_in, ext_addr;
	int          mismatches, cmp_count, i;
	int          cyc = 0;
	// ----------------------------------------------------------
	// design and partner
	// ----------------------------------------------------------
	mcd_decode dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cstore_word, .seq_ma,
		.flag_output, .micro_addr, .seq_input_bit3, .seq_int_req,
		.decode_addr, .ready_pin, .hold_pin, .int_req_pin, .hold_ack,
		.int_enable_out, .status_strobes, .flag_zero, .flag_parity,
		.flag_sign, .flag_carry, .flag_half_carry, .array1_data,
		.array2_data, .imar_in, .ext_addr, .dbus_in, .dbus_out, .dbus_oe,
		.kbus, .mask_bus, .reg_grp1, .reg_grp2, .array1_clk_en,
		.array2_clk_en, .carry_split, .instr_reg);
	mcd_bus_model bus_u (.aclk, .aresetn, .status_strobes, .dbus_oe, .hold_req,
		.int_req, .wait_cycles, .rd_data, .ready_pin, .hold_pin,
		.int_req_pin, .dbus_in);
	// ----------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// whole sequence needs well under a thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic results();
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [47:0] b(input int p);
		return 48'h1 << p;
	endfunction
	// new microword at one edge, captured at the next, sampled mid-cycle
	task automatic sw(input logic [47:0] w);
		@(posedge aclk);
		cstore_word <= w;
		@(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		logic ah, wh, bh;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ah = s_axi_awready & s_axi_awvalid;
			wh = s_axi_wready & s_axi_wvalid;
			@(posedge aclk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !ah) || (s_axi_wvalid && !wh));
		do begin
			@(negedge aclk);
			bh = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
		end while (!bh);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ah, vh;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ah = s_axi_arready;
			@(posedge aclk);
		end while (!ah);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			vh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!vh);
		chk("rdata", d, e);
		chk("rresp", r, er);
	endtask
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		cstore_word = 48'h0;
		seq_ma = 9'h013;
		{flag_output, flag_zero, flag_parity, flag_sign} = 4'hD;
		{flag_carry, flag_half_carry, hold_req, int_req} = 4'h8;
		{array1_data, array2_data, rd_data} = 24'h5AA5C3;
		imar_in = 16'hBEEF;
		wait_cycles = 4'h4;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rc(A_STAT, 32'h0, RESP_OK);
		rc(A_EMAR, 32'h0, RESP_OK);
		rc(A_GRP, 32'h0, RESP_DEC);
		wr(8'h20, 32'h1, r);
		chk("bresp_unmapped", r, RESP_DEC);
		hold_req <= 1'b1;
		sw(b(F_EXT) | b(F_CCR) | b(F_IRW) | b(F_STATUS_WORD_ADDR_LO));
		chk("ma_wait", micro_addr, 9'h012);
		chk("clk_wait", {array1_clk_en, array2_clk_en}, 2'h0);
		chk("strb_wait", status_strobes, 7'h01);
		chk("hold_ack_ext", hold_ack, 1'b0);
		for (i = 0; i < 40 && micro_addr[0] !== 1'b1; i++)
			@(negedge aclk);
		chk("ma_ready", micro_addr, 9'h013);
		chk("clk_rdy", {array1_clk_en, array2_clk_en}, 2'h3);
		chk("strb_ready", status_strobes, 7'h00);
		sw(48'h0);
		chk("ir_load", instr_reg, 8'hC3);
		chk("dec_addr", decode_addr, 9'h0C3);
		chk("hold_ack", hold_ack, 1'b1);
		sw(b(F_IST));
		chk("ma_ist_hold", micro_addr, 9'h003);
		chk("ireq_hold", seq_int_req, 1'b1);
		@(posedge aclk);
		hold_req <= 1'b0;
		int_req <= 1'b1;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("ma_ist", micro_addr, 9'h012);
		chk("ireq_int", seq_int_req, 1'b1);
		sw(48'h0);
		chk("ireq_off", seq_int_req, 1'b0);
		chk("ma_seq", micro_addr, 9'h013);
		kx = '{8'h00, 8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'hA5, 8'hC3, 8'h3C};
		for (i = 0; i < 8; i++) begin
			sw(48'(i) << F_KS_LO);
			chk("kbus", kbus, kx[i]);
		end
		sw(b(F_ED1) | b(F_DOE) | b(F_NC1) | b(F_DBY));
		chk("dbus_a2", dbus_out, 8'hA5);
		chk("dbus_oe", dbus_oe, 1'b1);
		chk("clk_nc1", {array1_clk_en, array2_clk_en}, 2'h1);
		chk("split", carry_split, 1'b1);
		sw(b(F_NC2));
		chk("dbus_a1", dbus_out, 8'h5A);
		chk("dbus_off", dbus_oe, 1'b0);
		chk("clk_nc2", {array1_clk_en, array2_clk_en}, 2'h2);
		chk("joined", carry_split, 1'b0);
		for (i = 0; i < 8; i++) begin
			sw(48'(i) << F_STATUS_WORD_ADDR_LO);
			d = i ? 32'h1 << (i - 1) : 32'h0;
			chk("strobes", status_strobes, d);
		end
		sw(b(F_IER) | b(F_FRW) | b(F_ADL));
		sw(48'h0);
		chk("int_enable_out_set", int_enable_out, 1'b1);
		chk("ext_addr", ext_addr, 16'hBEEF);
		rc(A_STAT, 32'h00000DC3, RESP_OK);
		rc(A_EMAR, 32'h0000BEEF, RESP_OK);
		@(posedge aclk);
		flag_output <= 1'b0;
		sw(b(F_IER));
		sw(b(F_SJM));
		chk("int_enable_out_clr", int_enable_out, 1'b0);
		chk("jump_miss", seq_input_bit3, 1'b0);
		chk("dec_sec", decode_addr, 9'h1C3);
		sw(b(F_SJM) | b(F_LD2));
		chk("jump_ld2", seq_input_bit3, 1'b1);
		@(posedge aclk);
		flag_zero <= 1'b0;
		sw(b(F_FRW));
		sw(b(F_SJM));
		chk("jump_hit", seq_input_bit3, 1'b1);
		wr(A_GRP, 32'h0588, r);
		chk("bresp_grp", r, RESP_OK);
		wr(A_MASK, 32'h165A, r);
		sw(48'h5 << F_RGP_LO | 48'h5 << F_IMB_LO);
		chk("grp", {reg_grp1, reg_grp2}, 8'h88);
		chk("mask", mask_bus, 8'h5A);
		sw(48'h5 << F_RGP_LO | b(F_RRE));
		chk("grp1_rre", reg_grp1, 4'hB);
		chk("grp2_rre", reg_grp2, 4'h8);
		chk("mask_idx", mask_bus, 8'h00);
		wr(A_CTRL, 32'h1, r);
		rc(A_CTRL, 32'h1, RESP_OK);
		sw(b(F_DBY));
		chk("frozen", carry_split, 1'b0);
		wr(A_CTRL, 32'h0, r);
		sw(b(F_DBY));
		chk("running", carry_split, 1'b1);
		results();
	end
endmodule
